// ===== core/ivp_pkg.sv
/*
 interrupt vectoring package: vector addresses, opcode codes, register offsets, field layouts.
 assumes a single core clock and synchronous reset.
*/
// Operation
// - undefined opcode raises illegal-opcode trap, vectoring to FF2012H in 1-Mbyte mode.
// - opcode bytes 10h and E5h are classified illegal and trapped.
// - opcode byte FFh acts as a reset instruction.
// - lowest-priority vector FF2000H taken only when its pending and enable bits set.
// - a source cleared before vectoring is aborted cleanly; no vector is taken.
// - external irq zero enabled by low enable bit 3; rising edge sets pending bit 3.
// - external irq zero standard service fetches vector 0FF2006H.
// - a transaction-selected source is served as a transaction cycle despite near races.
// - end-of-service interrupt only after the transaction count is exhausted.
// - setting a transaction-select bit re-enables microcoded servicing for that source.
// - software-set pending with select bit set yields a transaction cycle.
package ivp_pkg;
    localparam int NUM_SRC = 16;
    localparam logic [23:0] VEC_BASE = 24'hff2000;
    localparam logic [23:0] VEC_ILLEGAL = 24'hff2012;
    localparam logic [23:0] VEC_EXT0 = 24'hff2006;
    localparam logic [7:0] OPC_ILL_A = 8'h10;
    localparam logic [7:0] OPC_ILL_B = 8'he5;
    localparam logic [7:0] OPC_RESET = 8'hff;
    localparam int EXT0_BIT = 3;
    localparam logic [3:0] EXT0_SRC = 4'h3;
    // register offsets
    localparam logic [7:0] REG_ENABLE_LOW = 8'h00;
    localparam logic [7:0] REG_PENDING_LOW = 8'h04;
    localparam logic [7:0] REG_ENABLE_HIGH = 8'h08;
    localparam logic [7:0] REG_PENDING_HIGH = 8'h0c;
    localparam logic [7:0] REG_SELECT = 8'h10;
    localparam logic [7:0] REG_COUNT_IDX = 8'h14;
    localparam logic [7:0] REG_COUNT = 8'h18;
    localparam logic [7:0] REG_GLOBAL = 8'h1c;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h24;
    localparam logic [7:0] REG_IRQ_CLEAR = 8'h28;
    localparam logic [7:0] REG_PEND_SET = 8'h2c;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_COUNT = 8'h00;
    // status event bits
    localparam int EV_ILLEGAL = 0;
    localparam int EV_ABORT = 1;
    localparam int EV_END_SERV = 2;
    localparam int EV_RESET_OP = 3;
    localparam int NUM_EV = 4;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ivp_bus_t;

    typedef struct packed {
        logic valid;
        logic transaction;
        logic [3:0] source;
        logic [23:0] vector;
    } ivp_grant_t;
endpackage

// ===== core/ivp_ctrl.sv
/*
 interrupt request, masking, vector generation and transaction-service hand-off.
 assumes the sequencer pulses decode_valid per opcode and grant_ack once a grant is taken;
 external_irq_zero is an asynchronous pin.
*/
`timescale 1ns/1ns
module ivp_ctrl #(
    parameter int NUM_SRC = ivp_pkg::NUM_SRC
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire ivp_pkg::ivp_bus_t bus,
    output logic [15:0] rdata,
    // sources
    input wire logic external_irq_zero,
    input wire logic [NUM_SRC-1:0] periph_irq,
    // instruction decoder
    input wire logic decode_valid,
    input wire logic [7:0] decode_opcode,
    input wire logic [255:0] opcode_defined,
    // core sequencer
    input wire logic disable_interrupts_instr,
    input wire logic enable_interrupts_instr,
    input wire logic grant_ack,
    output ivp_pkg::ivp_grant_t grant,
    output logic reset_request,
    // interrupt
    output logic irq
);
    // the priority encoder and the vector map are written for sixteen sources
    if (NUM_SRC != 16) begin : g_bad_src
        $error("ivp_ctrl serves exactly 16 sources");
    end

    typedef enum {IDLE, OFFER} ivp_state_t;
    ivp_state_t state;

    logic [15:0] enable_mask;
    logic [15:0] pending;
    logic [15:0] transaction_service_select;
    logic [7:0] transaction_service_count [16];
    logic [3:0] count_index;
    logic global_enable;
    logic [ivp_pkg::NUM_EV-1:0] ev_status;
    logic [ivp_pkg::NUM_EV-1:0] ev_enable;
    logic [2:0] ext_sync;
    logic ext_level;
    logic [15:0] next_pending;
    logic [15:0] next_select;
    logic [15:0] active;
    logic [3:0] win_src;
    logic win_any;
    logic ill_op;
    logic rst_op;
    logic ev_abort;
    logic ev_end;
    logic trap_offer;
    logic trap_wait;
    logic trap_due;
    logic withdraw;
    logic [ivp_pkg::NUM_EV-1:0] ev_clear;

    // lowest index has lowest priority, highest index wins
    function automatic logic [4:0] pick_top(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) r = {1'b1, 4'(i)};
        end
        return r;
    endfunction

    function automatic logic [23:0] src_vector(input logic [3:0] s);
        return ivp_pkg::VEC_BASE + {19'h00000, s, 1'b0};
    endfunction

    // one decode for every write strobe keeps the offsets in a single place
    function automatic logic is_write(input ivp_pkg::ivp_bus_t b, input logic [7:0] offset);
        return b.wr && b.addr == offset;
    endfunction

    wire logic reg_wr_enable_low = is_write(bus, ivp_pkg::REG_ENABLE_LOW);
    wire logic reg_wr_enable_high = is_write(bus, ivp_pkg::REG_ENABLE_HIGH);
    wire logic reg_wr_pend_low = is_write(bus, ivp_pkg::REG_PENDING_LOW);
    wire logic reg_wr_pend_high = is_write(bus, ivp_pkg::REG_PENDING_HIGH);
    wire logic reg_wr_pend_set = is_write(bus, ivp_pkg::REG_PEND_SET);
    wire logic reg_wr_select = is_write(bus, ivp_pkg::REG_SELECT);
    wire logic reg_wr_count = is_write(bus, ivp_pkg::REG_COUNT);
    wire logic reg_wr_count_idx = is_write(bus, ivp_pkg::REG_COUNT_IDX);
    wire logic reg_wr_global = is_write(bus, ivp_pkg::REG_GLOBAL);
    wire logic reg_wr_irq_enable = is_write(bus, ivp_pkg::REG_IRQ_ENABLE);
    wire logic reg_wr_irq_clear = is_write(bus, ivp_pkg::REG_IRQ_CLEAR);

    // pin passes three flops; an edge counts when stages two and three agree
    wire logic ext_agree = ext_sync[2] == ext_sync[1];
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ext_sync <= 3'h0;
            ext_level <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], external_irq_zero};
            if (ext_agree) ext_level <= ext_sync[2];
        end
    end
    // a glitch shorter than one clock never reaches ext_level, so it raises nothing
    wire logic ext_rise = ext_agree && ext_sync[2] && !ext_level;

    assign ill_op = decode_valid && (decode_opcode == ivp_pkg::OPC_ILL_A ||
        decode_opcode == ivp_pkg::OPC_ILL_B ||
        (!opcode_defined[decode_opcode] && decode_opcode != ivp_pkg::OPC_RESET));
    assign rst_op = decode_valid && decode_opcode == ivp_pkg::OPC_RESET;
    assign active = pending & enable_mask;
    assign {win_any, win_src} = pick_top(active);

    // an illegal opcode met while a grant stands waits here, so the trap is never lost
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            trap_wait <= 1'b0;
        end else if (state == IDLE) begin
            trap_wait <= 1'b0;
        end else if (ill_op) begin
            trap_wait <= 1'b1;
        end
    end
    assign trap_due = ill_op || trap_wait;

    // hardware sets win over software clears in the same cycle
    always_comb begin
        next_pending = pending;
        if (reg_wr_pend_low) next_pending[7:0] = bus.wdata[7:0];
        if (reg_wr_pend_high) next_pending[15:8] = bus.wdata[7:0];
        if (reg_wr_pend_set) next_pending = next_pending | bus.wdata;
        next_pending = next_pending | periph_irq;
        if (ext_rise) next_pending[ivp_pkg::EXT0_BIT] = 1'b1;
        if (state == OFFER && grant_ack && !grant.transaction) begin
            next_pending[grant.source] = 1'b0;
        end
        if (state == OFFER && grant_ack && grant.transaction) begin
            next_pending[grant.source] = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pending <= ivp_pkg::RST_WORD;
        end else begin
            pending <= next_pending;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            enable_mask <= ivp_pkg::RST_WORD;
        end else begin
            if (reg_wr_enable_low) begin
                enable_mask[7:0] <= bus.wdata[7:0];
            end
            if (reg_wr_enable_high) begin
                enable_mask[15:8] <= bus.wdata[7:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            global_enable <= 1'b0;
        end else if (disable_interrupts_instr) begin
            global_enable <= 1'b0;
        end else if (enable_interrupts_instr) begin
            global_enable <= 1'b1;
        end else if (reg_wr_global) begin
            global_enable <= bus.wdata[0];
        end
    end

    // a transaction for the last count clears the select bit and posts end-of-service
    wire logic tx_take = state == OFFER && grant_ack && grant.transaction;
    wire logic tx_last = tx_take && transaction_service_count[grant.source] == 8'h01;
    always_comb begin
        next_select = transaction_service_select;
        if (tx_last) next_select[grant.source] = 1'b0;
        if (reg_wr_select) next_select = bus.wdata;
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            transaction_service_select <= ivp_pkg::RST_WORD;
        end else begin
            transaction_service_select <= next_select;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_index <= 4'h0;
            for (int i = 0; i < 16; i++) transaction_service_count[i] <= ivp_pkg::RST_COUNT;
        end else begin
            if (reg_wr_count_idx) begin
                count_index <= bus.wdata[3:0];
            end
            if (reg_wr_count) begin
                transaction_service_count[count_index] <= bus.wdata[7:0];
            end else if (tx_take && transaction_service_count[grant.source] != 8'h00) begin
                transaction_service_count[grant.source] <=
                    transaction_service_count[grant.source] - 8'h01;
            end
        end
    end

    // grant is re-checked every offered cycle so a cleared source is withdrawn
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= IDLE;
            grant <= '0;
            trap_offer <= 1'b0;
        end else begin
            unique case (state)
                IDLE: begin
                    if (trap_due) begin
                        grant <= '{1'b1, 1'b0, 4'h0, ivp_pkg::VEC_ILLEGAL};
                        trap_offer <= 1'b1;
                        state <= OFFER;
                    end else if (win_any && global_enable) begin
                        grant.valid <= 1'b1;
                        grant.source <= win_src;
                        grant.transaction <= transaction_service_select[win_src];
                        grant.vector <= (win_src == ivp_pkg::EXT0_SRC) ?
                            ivp_pkg::VEC_EXT0 : src_vector(win_src);
                        trap_offer <= 1'b0;
                        state <= OFFER;
                    end
                end
                OFFER: begin
                    if (grant_ack) begin
                        grant <= '0;
                        trap_offer <= 1'b0;
                        state <= IDLE;
                    end else if (withdraw) begin
                        grant <= '0;
                        state <= IDLE;
                    end
                end
            endcase
        end
    end

    // the trap is told apart by a flag, not by its vector, which source 9 shares
    assign withdraw = state == OFFER && !trap_offer &&
        (!active[grant.source] || !global_enable);
    assign ev_abort = withdraw && !grant_ack;
    assign ev_end = tx_last;

    always_ff @(posedge clock) begin
        // the sequencer performs the reset; this block only asks for it
        if (sys_rst) begin
            reset_request <= 1'b0;
        end else begin
            reset_request <= rst_op;
        end
    end

    // the clear register is write-only, so nothing but its write strobe clears
    assign ev_clear = reg_wr_irq_clear ? bus.wdata[ivp_pkg::NUM_EV-1:0] : '0;

    // sticky events; set wins over the write-one clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ev_status <= '0;
            ev_enable <= '0;
        end else begin
            if (reg_wr_irq_enable) begin
                ev_enable <= bus.wdata[ivp_pkg::NUM_EV-1:0];
            end
            ev_status <= (ev_status & ~ev_clear) | {rst_op, ev_end, ev_abort, ill_op};
        end
    end
    assign irq = |(ev_status & ev_enable);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata <= 16'h0000;
        end else if (bus.rd) begin
            unique case (bus.addr)
                ivp_pkg::REG_ENABLE_LOW: rdata <= {8'h00, enable_mask[7:0]};
                ivp_pkg::REG_PENDING_LOW: rdata <= {8'h00, pending[7:0]};
                ivp_pkg::REG_ENABLE_HIGH: rdata <= {8'h00, enable_mask[15:8]};
                ivp_pkg::REG_PENDING_HIGH: rdata <= {8'h00, pending[15:8]};
                ivp_pkg::REG_SELECT: rdata <= transaction_service_select;
                ivp_pkg::REG_COUNT_IDX: rdata <= {12'h000, count_index};
                ivp_pkg::REG_COUNT: rdata <= {8'h00, transaction_service_count[count_index]};
                ivp_pkg::REG_GLOBAL: rdata <= {15'h0000, global_enable};
                ivp_pkg::REG_IRQ_STATUS: rdata <= {12'h000, ev_status};
                ivp_pkg::REG_IRQ_ENABLE: rdata <= {12'h000, ev_enable};
                // write-only and unmapped offsets read as zero
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule // ivp_ctrl

// ===== tb/ivp_chk_props.sv
/*
 checker for ivp_ctrl: grant, vector, opcode-trap and register-read timing.
 assumes one clock and a synchronous active-high reset; sees top ports only.
*/
`timescale 1ns/1ns
module ivp_chk (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // watched ports
    input wire ivp_pkg::ivp_bus_t bus,
    input wire logic [15:0] rdata,
    input wire logic decode_valid,
    input wire logic [7:0] decode_opcode,
    input wire logic [255:0] opcode_defined,
    input wire logic grant_ack,
    input wire ivp_pkg::ivp_grant_t grant,
    input wire logic reset_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic ill_dec;
    logic [23:0] exp_vec;
    assign ill_dec = decode_valid && decode_opcode != ivp_pkg::OPC_RESET &&
        (!opcode_defined[decode_opcode] || decode_opcode == ivp_pkg::OPC_ILL_A ||
        decode_opcode == ivp_pkg::OPC_ILL_B);
    assign exp_vec = (grant.source == ivp_pkg::EXT0_SRC) ? ivp_pkg::VEC_EXT0
        : ivp_pkg::VEC_BASE + {19'h00000, grant.source, 1'b0};
    property p_rst_op; decode_valid && decode_opcode == 8'hff |=> reset_request; endproperty
    a_rst_op: assert property (p_rst_op) else $error("no reset request");
    property p_rst_cause; reset_request |-> $past(decode_valid && decode_opcode == 8'hff);
    endproperty
    a_rst_cause: assert property (p_rst_cause) else $error("stray reset request");
    property p_trap; ill_dec && !grant.valid && !$past(grant.valid)
        |=> grant.valid && grant.vector == ivp_pkg::VEC_ILLEGAL; endproperty
    a_trap: assert property (p_trap) else $error("illegal opcode not trapped");
    // source 9 owns the same vector as the trap; any other owner must be the trap
    property p_trap_src; grant.valid && grant.vector == ivp_pkg::VEC_ILLEGAL &&
        grant.source != 4'h9 |-> grant.source == 4'h0 && !grant.transaction; endproperty
    a_trap_src: assert property (p_trap_src) else $error("trap grant fields");
    property p_vec; grant.valid && !(grant.source == 4'h0 &&
        grant.vector == ivp_pkg::VEC_ILLEGAL) |-> grant.vector == exp_vec; endproperty
    a_vec: assert property (p_vec) else $error("vector mismatch");
    // a withdrawn grant must drop, never turn into another source's vector
    property p_no_subst; grant.valid && !grant_ack |=> !grant.valid || $stable(grant); endproperty
    a_no_subst: assert property (p_no_subst) else $error("grant substituted");
    property p_ack; grant.valid && grant_ack |=> !grant.valid; endproperty
    a_ack: assert property (p_ack) else $error("grant held after ack");
    property p_trap_hold; grant.valid && grant.vector == ivp_pkg::VEC_ILLEGAL &&
        grant.source == 4'h0 && !grant_ack |=> grant.valid; endproperty
    a_trap_hold: assert property (p_trap_hold) else $error("trap withdrawn");
    property p_rd_idle; !$past(bus.rd) |-> rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule // ivp_chk
bind ivp_ctrl ivp_chk u_chk (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .decode_valid(decode_valid), .decode_opcode(decode_opcode),
    .opcode_defined(opcode_defined), .grant_ack(grant_ack), .grant(grant),
    .reset_request(reset_request));

// ===== tb/ivp_seq_model.sv
/*
 core sequencer model: takes each offered grant once, or leaves it standing.
 assumes grant_valid comes from a register of the same clock.
*/
`timescale 1ns/1ns
module ivp_seq_model (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // grant handshake
    input wire logic grant_valid,
    input wire logic ack_en,
    output logic grant_ack
);
    // one-cycle ack; ack_en low models a sequencer still busy elsewhere
    always_ff @(posedge clock) begin
        if (sys_rst) grant_ack <= 1'b0;
        else grant_ack <= grant_valid && !grant_ack && ack_en;
    end
endmodule // ivp_seq_model

// ===== tb/ivp_ctrl_tb_top.sv
/*
 testbench for ivp_ctrl: registers, traps, masking, aborts, transaction hand-off.
 assumes the sequencer model in ivp_seq_model and the bound checker.
*/
`timescale 1ns/1ns
module ivp_ctrl_tb_top;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    ivp_pkg::ivp_bus_t bus = '0;
    logic [15:0] rdata, periph_irq = 16'h0000;
    logic external_irq_zero = 1'b0, decode_valid = 1'b0, ack_en = 1'b1;
    logic disable_interrupts_instr = 1'b0, enable_interrupts_instr = 1'b0;
    logic [7:0] decode_opcode = 8'h00;
    logic [255:0] opcode_defined = {256{1'b1}};
    logic grant_ack, reset_request, irq;
    ivp_pkg::ivp_grant_t grant;
    int miscompares = 0, checks = 0;
    always #4 clock = ~clock;
    ivp_ctrl u_dut (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
        .external_irq_zero(external_irq_zero), .periph_irq(periph_irq),
        .decode_valid(decode_valid), .decode_opcode(decode_opcode),
        .opcode_defined(opcode_defined), .disable_interrupts_instr(disable_interrupts_instr),
        .enable_interrupts_instr(enable_interrupts_instr), .grant_ack(grant_ack),
        .grant(grant), .reset_request(reset_request), .irq(irq));
    ivp_seq_model u_seq (.clock(clock), .sys_rst(sys_rst), .grant_valid(grant.valid),
        .ack_en(ack_en), .grant_ack(grant_ack));
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock) bus <= {1'b1, 1'b0, a, d};
        @(posedge clock) bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
        @(posedge clock) bus <= {1'b0, 1'b1, a, 16'h0000};
        @(posedge clock) bus <= '0;
        #1 chk(n, rdata, e);
    endtask
    task automatic dec(input logic [7:0] op);
        @(posedge clock) {decode_valid, decode_opcode} <= {1'b1, op};
        @(posedge clock) decode_valid <= 1'b0;
        #1;
    endtask
    // waits bounded; the sequencer model acks unless ack_en is low
    task automatic wait_grant(input logic [23:0] v, input logic t, input string n);
        for (int i = 0; i < 20 && grant.valid !== 1'b1; i++) @(posedge clock) #1;
        chk(n, {grant.valid, grant.transaction, 6'h00, grant.vector}, {1'b1, t, 6'h00, v});
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic t_regs;
        rd(ivp_pkg::REG_ENABLE_LOW, 16'h0000, "enable_low_reset");
        wr(ivp_pkg::REG_ENABLE_LOW, 16'h0008);
        rd(ivp_pkg::REG_ENABLE_LOW, 16'h0008, "enable_low");
        wr(ivp_pkg::REG_IRQ_STATUS, 16'hffff);
        rd(ivp_pkg::REG_IRQ_STATUS, 16'h0000, "status_read_only");
        rd(8'h30, 16'h0000, "unmapped");
        $display("test regs done");
    endtask
    task automatic t_traps;
        wr(ivp_pkg::REG_IRQ_ENABLE, 16'h000f);
        // 10h and e5h stay marked defined in opcode_defined, so only the fixed decode can trap them
        for (int k = 0; k < 3; k++) begin
            dec(k == 0 ? 8'h10 : (k == 1 ? 8'he5 : 8'h42));
            wait_grant(ivp_pkg::VEC_ILLEGAL, 1'b0, "trap_vector");
            chk("irq_raised", irq, 1'b1);
            wr(ivp_pkg::REG_IRQ_CLEAR, 16'h0001);
            chk("irq_cleared", irq, 1'b0);
        end
        dec(ivp_pkg::OPC_RESET);
        chk("reset_request", reset_request, 1'b1);
        rd(ivp_pkg::REG_IRQ_STATUS, 16'h0008, "reset_op_status");
        wr(ivp_pkg::REG_IRQ_ENABLE, 16'h0000);
        chk("irq_masked", irq, 1'b0);
        wr(ivp_pkg::REG_IRQ_CLEAR, 16'h000f);
        $display("test traps done");
    endtask
    task automatic t_ext0;
        @(posedge clock) enable_interrupts_instr <= 1'b1;
        @(posedge clock) {enable_interrupts_instr, external_irq_zero} <= 2'b01;
        wait_grant(ivp_pkg::VEC_EXT0, 1'b0, "ext0_vector");
        rd(ivp_pkg::REG_PENDING_LOW, 16'h0000, "ext0_pending_taken");
        @(posedge clock) external_irq_zero <= 1'b0;
        $display("test ext0 done");
    endtask
    task automatic t_lowest;
        @(posedge clock) ack_en <= 1'b0;
        wr(ivp_pkg::REG_ENABLE_LOW, 16'h0000);
        wr(ivp_pkg::REG_PEND_SET, 16'h0001);
        repeat (10) @(posedge clock);
        chk("masked_no_grant", grant.valid, 1'b0);
        wr(ivp_pkg::REG_ENABLE_LOW, 16'h0001);
        wait_grant(ivp_pkg::VEC_BASE, 1'b0, "lowest_vector");
        wr(ivp_pkg::REG_ENABLE_LOW, 16'h0000);
        repeat (2) @(posedge clock);
        chk("abort_no_vector", grant.valid, 1'b0);
        rd(ivp_pkg::REG_IRQ_STATUS, 16'h0002, "abort_status");
        wr(ivp_pkg::REG_ENABLE_LOW, 16'h0001);
        wait_grant(ivp_pkg::VEC_BASE, 1'b0, "lowest_again");
        // software guard: interrupts off around the pending clear
        @(posedge clock) disable_interrupts_instr <= 1'b1;
        @(posedge clock) disable_interrupts_instr <= 1'b0;
        wr(ivp_pkg::REG_PENDING_LOW, 16'h0000);
        @(posedge clock) enable_interrupts_instr <= 1'b1;
        @(posedge clock) {enable_interrupts_instr, ack_en} <= 2'b01;
        repeat (4) @(posedge clock);
        chk("cleared_no_grant", grant.valid, 1'b0);
        wr(ivp_pkg::REG_IRQ_CLEAR, 16'h000f);
        $display("test lowest done");
    endtask
    task automatic t_pts;
        wr(ivp_pkg::REG_ENABLE_LOW, 16'h000a);
        wr(ivp_pkg::REG_SELECT, 16'h0008);
        wr(ivp_pkg::REG_COUNT_IDX, 16'h0003);
        wr(ivp_pkg::REG_COUNT, 16'h0002);
        wr(ivp_pkg::REG_PEND_SET, 16'h000a);
        wait_grant(ivp_pkg::VEC_EXT0, 1'b1, "race_transaction");
        wait_grant(ivp_pkg::VEC_BASE + 24'h2, 1'b0, "race_standard");
        wr(ivp_pkg::REG_PEND_SET, 16'h0008);
        wait_grant(ivp_pkg::VEC_EXT0, 1'b1, "last_transaction");
        rd(ivp_pkg::REG_SELECT, 16'h0000, "select_done");
        rd(ivp_pkg::REG_IRQ_STATUS, 16'h0004, "end_status");
        wr(ivp_pkg::REG_PEND_SET, 16'h0008);
        wait_grant(ivp_pkg::VEC_EXT0, 1'b0, "end_of_service");
        wr(ivp_pkg::REG_COUNT, 16'h0001);
        wr(ivp_pkg::REG_SELECT, 16'h0008);
        wr(ivp_pkg::REG_PEND_SET, 16'h0008);
        wait_grant(ivp_pkg::VEC_EXT0, 1'b1, "reselected");
        $display("test pts done");
    endtask
    task automatic conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        opcode_defined[8'h42] <= 1'b0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        t_regs();
        t_traps();
        t_ext0();
        t_lowest();
        t_pts();
        conclude();
    end
    // whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule // ivp_ctrl_tb_top
